// File: shared/msc_defines.vh
// msc_defines.vh: offsets, field positions, reset values and timing counts
// for the system control pin block; assumes 32-bit APB data, word offsets.
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH

`define MSC_OFF_CTRL        8'h00
`define MSC_OFF_STATUS      8'h04
`define MSC_OFF_ACK         8'h08

// control register fields
`define MSC_CTRL_EDGE_SEL   0
`define MSC_CTRL_ECLK_DIS   1
`define MSC_CTRL_STOP       2
`define MSC_CTRL_NMI_MASK   3
`define MSC_CTRL_IRQ_MASK   4
`define MSC_CTRL_RESET      5'h18

// status register fields
`define MSC_ST_MODE_LO      0
`define MSC_ST_MODE_HI      1
`define MSC_ST_RST_EXT      2
`define MSC_ST_RST_INT      3
`define MSC_ST_IRQ_REQ      4
`define MSC_ST_NMI_REQ      5
`define MSC_ST_MODE_VALID   6

`define MSC_ACK_IRQ         0

// operating mode encoding {mode_strap_high, mode_strap_low}
`define MSC_MODE_BOOT       2'h0
`define MSC_MODE_SINGLE     2'h1
`define MSC_MODE_TEST       2'h2
`define MSC_MODE_EXPANDED   2'h3

// timing
`define MSC_ECLK_DIV        4
`define MSC_RST_DRIVE_ECYC  4
`define MSC_RST_SENSE_ECYC  2

`endif

// File: rtl/msc_eclk.v
// msc_eclk: bus clock phase generator, one quarter of pclk, as enables.
// assumes pclk is the oscillator input; stop and gating come from the top.
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.vh"

module msc_eclk (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       stop,
    input  wire       pin_disable,
    input  wire [1:0] op_mode,
    output reg        eclk_q,
    output reg        eclk_pin_q,
    output reg        e_tick_q,
    output reg        access_q
);
    reg  [1:0] phase_q;
    wire       single_chip;

    assign single_chip = (op_mode == `MSC_MODE_SINGLE) || (op_mode == `MSC_MODE_BOOT);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q    <= 2'h0;
            eclk_q     <= 1'b0;
            eclk_pin_q <= 1'b0;
            e_tick_q   <= 1'b0;
            access_q   <= 1'b0;
        end else if (stop) begin
            // every output freezes low and the phase count holds, so no stray edge leaves the pin
            eclk_q     <= 1'b0;
            eclk_pin_q <= 1'b0;
            e_tick_q   <= 1'b0;
            access_q   <= 1'b0;
        end else begin
            phase_q    <= phase_q + 2'h1;
            eclk_q     <= phase_q[1];
            eclk_pin_q <= phase_q[1] & ~(pin_disable & single_chip);
            e_tick_q   <= (phase_q == 2'h3);
            access_q   <= phase_q[1];
        end
    end
endmodule
`default_nettype wire

// File: rtl/msc_irq.v
// msc_irq: maskable and nonmaskable request conditioning.
// assumes pin inputs arrive already synchronised to pclk.
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.vh"

module msc_irq (
    input  wire pclk,
    input  wire presetn,
    input  wire sys_reset,
    input  wire irq_n_s,
    input  wire nmi_n_s,
    input  wire edge_sel,
    input  wire irq_mask,
    input  wire nmi_mask,
    input  wire irq_ack,
    output reg  irq_req_q,
    output reg  nmi_req_q
);
    reg  irq_prev_q;
    reg  edge_pend_q;
    wire fall;
    wire pending;

    assign fall    = irq_prev_q & ~irq_n_s;
    assign pending = edge_sel ? edge_pend_q : ~irq_n_s;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev_q  <= 1'b1;
            edge_pend_q <= 1'b0;
            irq_req_q   <= 1'b0;
            nmi_req_q   <= 1'b0;
        end else if (sys_reset) begin
            irq_prev_q  <= irq_n_s;
            edge_pend_q <= 1'b0;
            irq_req_q   <= 1'b0;
            nmi_req_q   <= 1'b0;
        end else begin
            irq_prev_q <= irq_n_s;
            // a new edge in the ack cycle stays pending
            if (fall)
                edge_pend_q <= 1'b1;
            else if (irq_ack)
                edge_pend_q <= 1'b0;
            // a line still held low comes back once the mask drops
            irq_req_q <= pending & ~irq_mask;
            nmi_req_q <= ~nmi_n_s & ~nmi_mask;
        end
    end
endmodule
`default_nettype wire

// File: rtl/msc_top.v
// msc_top: system control pins: reset pin, mode straps, fetch indicator,
// APB registers. assumes pins are asynchronous, failure and fetch inputs
// come from pclk logic, and an external pullup on every open-drain pin.
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.vh"

module msc_top #(
    parameter ADDR_W     = 8,
    parameter DRIVE_ECYC = `MSC_RST_DRIVE_ECYC,
    parameter SENSE_ECYC = `MSC_RST_SENSE_ECYC
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire [ADDR_W-1:0] paddr,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire              reset_pin_i,
    output reg               reset_pin_o,
    output reg               reset_pin_oe,
    input  wire              clock_monitor_fail,
    input  wire              watchdog_timer_fail,
    input  wire              irq_pin_n,
    input  wire              nonmaskable_interrupt_input_n,
    input  wire              mode_strap_low,
    input  wire              mode_strap_high,
    input  wire              instr_start,
    output reg               opcode_fetch_indicator_o,
    output reg               opcode_fetch_indicator_oe,
    output wire              eclk,
    output wire              eclk_pin,
    output wire              e_tick,
    output reg               sys_reset,
    output reg  [1:0]        op_mode,
    output reg               mode_valid,
    output wire              irq_req,
    output wire              nmi_req
);
    localparam ST_RUN   = 2'h0;
    localparam ST_DRIVE = 2'h1;
    localparam ST_SENSE = 2'h2;
    localparam ST_EXT   = 2'h3;

    // pin synchronisers: stage one feeds only stage two
    reg  [4:0] sync1_q;
    reg  [4:0] sync2_q;
    wire [4:0] pins;
    wire       rst_s;
    wire       irq_s;
    wire       nmi_s;
    wire       mlo_s;
    wire       mhi_s;

    assign pins  = {mode_strap_high, mode_strap_low, nonmaskable_interrupt_input_n, irq_pin_n, reset_pin_i};
    assign rst_s = sync2_q[0];
    assign irq_s = sync2_q[1];
    assign nmi_s = sync2_q[2];
    assign mlo_s = sync2_q[3];
    assign mhi_s = sync2_q[4];

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_sync
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    // reset pin starts low: leaving reset needs a real high seen
                    sync1_q[g] <= (g == 0) ? 1'b0 : 1'b1;
                    sync2_q[g] <= (g == 0) ? 1'b0 : 1'b1;
                end else begin
                    sync1_q[g] <= pins[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    reg  [4:0] ctrl_q;
    reg        irq_ack_q;
    wire       access;

    msc_eclk u_eclk (
        .pclk        (pclk),
        .presetn     (presetn),
        .stop        (ctrl_q[`MSC_CTRL_STOP]),
        .pin_disable (ctrl_q[`MSC_CTRL_ECLK_DIS]),
        .op_mode     (op_mode),
        .eclk_q      (eclk),
        .eclk_pin_q  (eclk_pin),
        .e_tick_q    (e_tick),
        .access_q    (access)
    );

    msc_irq u_irq (
        .pclk      (pclk),
        .presetn   (presetn),
        .sys_reset (sys_reset),
        .irq_n_s   (irq_s),
        .nmi_n_s   (nmi_s),
        .edge_sel  (ctrl_q[`MSC_CTRL_EDGE_SEL]),
        .irq_mask  (ctrl_q[`MSC_CTRL_IRQ_MASK]),
        .nmi_mask  (ctrl_q[`MSC_CTRL_NMI_MASK]),
        .irq_ack   (irq_ack_q),
        .irq_req_q (irq_req),
        .nmi_req_q (nmi_req)
    );

    // reset pin sequencer
    reg  [1:0] st_q;
    reg  [1:0] st_d;
    reg  [2:0] cnt_q;
    reg  [2:0] cnt_d;
    reg        rst_int_q;
    reg        rst_ext_q;

    always @* begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_RUN: begin
                cnt_d = 3'h0;
                if (clock_monitor_fail || watchdog_timer_fail)
                    st_d = ST_DRIVE;
                else if (!rst_s)
                    st_d = ST_EXT;
            end
            ST_DRIVE: begin
                if (e_tick) begin
                    if (cnt_q == DRIVE_ECYC[2:0] - 3'h1) begin
                        st_d  = ST_SENSE;
                        cnt_d = 3'h0;
                    end else begin
                        cnt_d = cnt_q + 3'h1;
                    end
                end
            end
            ST_SENSE: begin
                // pin still low after the window: someone outside holds it
                if (rst_s)
                    st_d = ST_RUN;
                else if (e_tick) begin
                    if (cnt_q == SENSE_ECYC[2:0] - 3'h1)
                        st_d = ST_EXT;
                    else
                        cnt_d = cnt_q + 3'h1;
                end
            end
            ST_EXT: begin
                if (rst_s)
                    st_d = ST_RUN;
            end
            default: begin
                st_d = ST_EXT;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q         <= ST_EXT;
            cnt_q        <= 3'h0;
            sys_reset    <= 1'b1;
            reset_pin_o  <= 1'b0;
            reset_pin_oe <= 1'b0;
            rst_int_q    <= 1'b0;
            rst_ext_q    <= 1'b0;
            op_mode      <= 2'h0;
            mode_valid   <= 1'b0;
        end else begin
            st_q         <= st_d;
            cnt_q        <= cnt_d;
            sys_reset    <= (st_d != ST_RUN);
            reset_pin_o  <= 1'b0;
            reset_pin_oe <= (st_d == ST_DRIVE);
            if (st_q == ST_SENSE && st_d == ST_RUN) begin
                rst_int_q <= 1'b1;
                rst_ext_q <= 1'b0;
            end else if (st_q == ST_EXT && st_d == ST_RUN) begin
                rst_int_q <= 1'b0;
                rst_ext_q <= 1'b1;
            end
            // straps sampled as reset lets go, frozen until the next one
            if (st_q != ST_RUN && st_d == ST_RUN) begin
                op_mode    <= {mhi_s, mlo_s};
                mode_valid <= 1'b1;
            end else if (st_d != ST_RUN) begin
                mode_valid <= 1'b0;
            end
        end
    end

    // opcode fetch indicator, held for one full bus cycle
    reg [1:0] fetch_cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_cnt_q               <= 2'h0;
            opcode_fetch_indicator_o  <= 1'b0;
            opcode_fetch_indicator_oe <= 1'b0;
        end else begin
            opcode_fetch_indicator_o <= 1'b0;
            if (instr_start && mode_valid && !sys_reset) begin
                opcode_fetch_indicator_oe <= 1'b1;
                fetch_cnt_q               <= 2'h3;
            end else if (fetch_cnt_q != 2'h0) begin
                fetch_cnt_q <= fetch_cnt_q - 2'h1;
            end else begin
                opcode_fetch_indicator_oe <= 1'b0;
            end
        end
    end

    // apb slave: answers only in the high bus-clock phase
    wire       acc;
    wire       wr;
    reg [31:0] rd_d;
    reg        err_d;

    assign acc = psel & penable;
    assign wr  = acc & pwrite & pready;

    always @* begin
        rd_d  = 32'h0;
        err_d = 1'b0;
        case (paddr)
            `MSC_OFF_CTRL:   rd_d = {27'h0, ctrl_q};
            `MSC_OFF_STATUS: rd_d = {25'h0, mode_valid, nmi_req, irq_req, rst_int_q, rst_ext_q, op_mode};
            `MSC_OFF_ACK:    rd_d = 32'h0;
            default:         err_d = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            if (acc && !pready && access) begin
                pready  <= 1'b1;
                pslverr <= err_d;
                prdata  <= pwrite ? 32'h0 : rd_d;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `MSC_CTRL_RESET;
            irq_ack_q <= 1'b0;
        end else if (sys_reset) begin
            ctrl_q    <= `MSC_CTRL_RESET;
            irq_ack_q <= 1'b0;
        end else begin
            irq_ack_q <= wr && (paddr == `MSC_OFF_ACK) && pwdata[`MSC_ACK_IRQ];
            if (wr && paddr == `MSC_OFF_CTRL) begin
                ctrl_q[`MSC_CTRL_EDGE_SEL] <= pwdata[`MSC_CTRL_EDGE_SEL];
                ctrl_q[`MSC_CTRL_ECLK_DIS] <= pwdata[`MSC_CTRL_ECLK_DIS];
                ctrl_q[`MSC_CTRL_STOP]     <= pwdata[`MSC_CTRL_STOP];
                ctrl_q[`MSC_CTRL_IRQ_MASK] <= pwdata[`MSC_CTRL_IRQ_MASK];
                // software may only clear the nonmaskable mask
                if (!pwdata[`MSC_CTRL_NMI_MASK])
                    ctrl_q[`MSC_CTRL_NMI_MASK] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/msc_ext_model.sv
// msc_ext_model: reset supervisor and open-drain interrupt sources.
// assumes pullups on reset and interrupt lines; events are pclk pulses.
`timescale 1ns/100ps
`default_nettype none
module msc_ext_model (
    input  wire logic pclk,
    input  wire logic sup_hold,
    input  wire logic reset_pin_o,
    input  wire logic reset_pin_oe,
    input  wire logic irq_raise,
    input  wire logic irq_ack,
    input  wire logic nmi_raise,
    input  wire logic nmi_ack,
    output var  logic reset_pin_lvl,
    output var  logic irq_pin_n,
    output var  logic nmi_pin_n
);
    logic irq_hold_q = 1'b0;
    logic nmi_hold_q = 1'b0;
    // wired line: any party pulling low wins over the pullup
    always_comb reset_pin_lvl = !(sup_hold || (reset_pin_oe && !reset_pin_o));
    always_comb irq_pin_n = !irq_hold_q;
    always_comb nmi_pin_n = !nmi_hold_q;
    // a source keeps its line low until serviced
    always @(posedge pclk) begin
        if (irq_raise)
            irq_hold_q <= 1'b1;
        else if (irq_ack)
            irq_hold_q <= 1'b0;
        if (nmi_raise)
            nmi_hold_q <= 1'b1;
        else if (nmi_ack)
            nmi_hold_q <= 1'b0;
    end
endmodule
`default_nettype wire

// File: bench/msc_checker.sv
// msc_checker: port-level assertions for msc_top.
// assumes pclk and the async active-low presetn of the top.
`timescale 1ns/100ps
`default_nettype none
module msc_checker (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       reset_pin_i,
    input wire logic       reset_pin_o,
    input wire logic       reset_pin_oe,
    input wire logic       clock_monitor_fail,
    input wire logic       watchdog_timer_fail,
    input wire logic       instr_start,
    input wire logic       opcode_fetch_indicator_o,
    input wire logic       opcode_fetch_indicator_oe,
    input wire logic       eclk,
    input wire logic       e_tick,
    input wire logic       sys_reset,
    input wire logic [1:0] op_mode,
    input wire logic       mode_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    eclk_high_a: assert property ($rose(eclk) |=> eclk)
        else $error("bus clock high phase too short");
    eclk_low_a: assert property ($fell(eclk) |=> !eclk)
        else $error("bus clock low phase too short");
    tick_space_a: assert property (e_tick |=> !e_tick [*3])
        else $error("bus cycle tick too frequent");
    open_drain_a: assert property (!reset_pin_o && !opcode_fetch_indicator_o)
        else $error("open-drain pin driven high");
    access_phase_a: assert property (pready |-> psel && penable && (eclk || $past(eclk)))
        else $error("bus answer outside high phase");
    fail_drive_a: assert property ((watchdog_timer_fail || clock_monitor_fail) && !sys_reset && !reset_pin_oe
        |-> ##[1:3] reset_pin_oe)
        else $error("failure did not pull reset pin");
    drive_len_a: assert property ($rose(reset_pin_oe) |-> reset_pin_oe [*8] ##[1:12] !reset_pin_oe)
        else $error("reset pin drive length wrong");
    ext_reset_a: assert property (!reset_pin_i |-> ##[1:4] sys_reset)
        else $error("low reset pin not obeyed");
    mode_hold_a: assert property (!sys_reset && !$past(sys_reset) && !$past(sys_reset, 2)
        |-> $stable(op_mode))
        else $error("mode changed outside reset");
    mode_reset_a: assert property (sys_reset && $past(sys_reset) |-> !mode_valid)
        else $error("mode valid during reset");
    fetch_pulse_a: assert property (instr_start && mode_valid |=> opcode_fetch_indicator_oe [*4])
        else $error("fetch indicator too short");
    cover property ($rose(reset_pin_oe));
    cover property (pready && psel && penable);
    cover property (instr_start && mode_valid);
endmodule
bind msc_top msc_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
    .clock_monitor_fail(clock_monitor_fail), .watchdog_timer_fail(watchdog_timer_fail),
    .instr_start(instr_start), .opcode_fetch_indicator_o(opcode_fetch_indicator_o),
    .opcode_fetch_indicator_oe(opcode_fetch_indicator_oe), .eclk(eclk), .e_tick(e_tick),
    .sys_reset(sys_reset), .op_mode(op_mode), .mode_valid(mode_valid));
`default_nettype wire

// File: bench/testbench.sv
// testbench: APB-driven checks of msc_top against pin and register behaviour.
// assumes msc_ext_model for supervisor and interrupt sources.
`timescale 1ns/100ps
`default_nettype none
`include "msc_defines.vh"
module testbench;
    localparam int FETCH = 0, WDOG = 1, CMON = 2, IRQ_ON = 3, IRQ_OFF = 4, NMI_ON = 5, NMI_OFF = 6;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        sup_hold = 1'b0;
    logic [1:0]  strap = 2'h2;
    logic [6:0]  ev = 7'h00;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, rst_lvl, irq_n, nmi_n, pin_o, pin_oe, foe, eclk, eclk_pin;
    logic        sys_reset, mode_valid, irq_req, nmi_req;
    logic [1:0]  op_mode;
    int          n_fail = 0, n_tests = 0, c_e, c_p;

    always #10 pclk = ~pclk;

    msc_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_pin_i(rst_lvl), .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .clock_monitor_fail(ev[CMON]),
        .watchdog_timer_fail(ev[WDOG]), .irq_pin_n(irq_n), .nonmaskable_interrupt_input_n(nmi_n),
        .mode_strap_low(strap[0]), .mode_strap_high(strap[1]), .instr_start(ev[FETCH]),
        .opcode_fetch_indicator_o(), .opcode_fetch_indicator_oe(foe), .eclk(eclk), .eclk_pin(eclk_pin),
        .e_tick(), .sys_reset(sys_reset), .op_mode(op_mode), .mode_valid(mode_valid), .irq_req(irq_req),
        .nmi_req(nmi_req));
    msc_ext_model i_ext (.pclk(pclk), .sup_hold(sup_hold), .reset_pin_o(pin_o), .reset_pin_oe(pin_oe),
        .irq_raise(ev[IRQ_ON]), .irq_ack(ev[IRQ_OFF]), .nmi_raise(ev[NMI_ON]), .nmi_ack(ev[NMI_OFF]),
        .reset_pin_lvl(rst_lvl), .irq_pin_n(irq_n), .nmi_pin_n(nmi_n));

    task automatic end_sim;
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic to_fail;
        n_fail++;
        end_sim;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // master waits for pready as long as the slave needs, within a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 40);
        if (pready !== 1'b1)
            to_fail;
        else begin
            rd = prdata;
            chk(pslverr, e);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev[b] <= 1'b0;
    endtask

    task automatic wait_run;
        int i = 0;
        while (sys_reset !== 1'b0 && i < 100) begin
            @(posedge pclk);
            i++;
        end
        if (i >= 100)
            to_fail;
    endtask

    task automatic wait_drive;
        int i = 0;
        while (pin_oe !== 1'b1 && i < 20) begin
            @(posedge pclk);
            i++;
        end
        if (i >= 20)
            to_fail;
    endtask

    task automatic count(input int n);
        logic pe, pp;
        pe = eclk;
        pp = eclk_pin;
        c_e = 0;
        c_p = 0;
        repeat (n) begin
            @(posedge pclk);
            c_e += (eclk && !pe);
            c_p += (eclk_pin && !pp);
            pe = eclk;
            pp = eclk_pin;
        end
    endtask

    task automatic sense(input int n, input logic [31:0] exp);
        repeat (n) @(posedge pclk);
        chk(exp[0] ? irq_req : nmi_req, exp[1]);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wait_run;
        chk(op_mode, 2'h2);
        for (int m = 0; m < 4; m++) begin
            strap <= m[1:0];
            sup_hold <= 1'b1;
            repeat (10) @(posedge pclk);
            sup_hold <= 1'b0;
            wait_run;
            strap <= ~m[1:0];
            apb(1'b0, `MSC_OFF_CTRL, 32'h0, 1'b0);
            chk(rd, 32'h18);
            apb(1'b0, `MSC_OFF_STATUS, 32'h0, 1'b0);
            chk(rd, 32'h44 | m);
            chk(op_mode, m);
            apb(1'b1, `MSC_OFF_CTRL, 32'h1A, 1'b0);
            count(16);
            chk(c_p, (m < 2) ? 0 : 4);
            chk(c_e, 4);
        end
        pulse(FETCH);
        repeat (4) begin
            #1 chk(foe, 1);
            @(posedge pclk);
        end
        #1 chk(foe, 0);
        apb(1'b0, 8'h0C, 32'h0, 1'b1); // unmapped place is refused
        apb(1'b0, `MSC_OFF_ACK, 32'h0, 1'b0);
        chk(rd, 32'h0);
        pulse(IRQ_ON);
        sense(8, 32'h1);
        apb(1'b1, `MSC_OFF_CTRL, 32'h08, 1'b0);
        sense(8, 32'h3);
        apb(1'b1, `MSC_OFF_CTRL, 32'h18, 1'b0);
        sense(4, 32'h1);
        apb(1'b1, `MSC_OFF_CTRL, 32'h08, 1'b0);
        sense(4, 32'h3);
        pulse(IRQ_OFF);
        sense(8, 32'h1);
        // edge mode only with a single source on the line
        apb(1'b1, `MSC_OFF_CTRL, 32'h09, 1'b0);
        pulse(IRQ_ON);
        pulse(IRQ_OFF);
        sense(8, 32'h3);
        apb(1'b1, `MSC_OFF_ACK, 32'h1, 1'b0);
        sense(3, 32'h1);
        pulse(NMI_ON);
        sense(8, 32'h0);
        apb(1'b1, `MSC_OFF_CTRL, 32'h10, 1'b0);
        sense(16, 32'h2);
        pulse(NMI_OFF);
        sense(8, 32'h0);
        strap <= 2'h3;
        pulse(WDOG);
        wait_drive;
        wait_run;
        apb(1'b0, `MSC_OFF_STATUS, 32'h0, 1'b0);
        chk(rd, 32'h4B);
        pulse(CMON);
        wait_drive;
        sup_hold <= 1'b1;
        repeat (40) @(posedge pclk);
        sup_hold <= 1'b0;
        wait_run;
        apb(1'b0, `MSC_OFF_STATUS, 32'h0, 1'b0);
        chk(rd, 32'h47);
        apb(1'b1, `MSC_OFF_CTRL, 32'h1C, 1'b0);
        repeat (2) @(posedge pclk);
        count(16);
        chk(c_e, 0);
        chk(eclk_pin, 0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_run;
        apb(1'b0, `MSC_OFF_CTRL, 32'h0, 1'b0);
        chk(rd, 32'h18);
        count(16);
        chk(c_e, 4);
        end_sim;
    end
endmodule
`default_nettype wire
